//--- rtl/asip_pkg.sv
package asip_pkg;
    localparam int ASIP_IRQ_VEC_W = 4;
    localparam logic [3:0] ASIP_KBD_VEC      = 4'h1;
    localparam logic [3:0] ASIP_SPURIOUS_VEC = 4'h7;
    localparam logic [3:0] ASIP_NONE_VEC     = 4'hF;
    localparam int ASIP_ADDR_W = 32;
    localparam logic [31:0] ASIP_WIN_BASE_RST = 32'hFEC00000;
    localparam logic [31:0] ASIP_WIN_MASK_RST = 32'hFFFFFF00;
    localparam int ASIP_DRAIN_W = 4;
    localparam logic [3:0] ASIP_DRAIN_CYCLES = 4'h4;
    localparam logic [3:0] ASIP_DRAIN_ZERO   = 4'h0;
    localparam logic [3:0] ASIP_DRAIN_ONE    = 4'h1;
    localparam logic ASIP_PIN_IDLE = 1'b1;
    localparam logic ASIP_MIRROR_RST = 1'b0;
    typedef enum logic [1:0] {
        ASIP_FL_IDLE,
        ASIP_FL_DRAIN,
        ASIP_FL_ACK
    } asip_flush_state_type;
endpackage : asip_pkg

//--- rtl/asip_sideband_if.sv
`timescale 1ns/10ps
interface asip_sideband_if;
    logic flushReqN;
    logic flushAckN;
    logic intcChipSelN;
    logic timerIrqMirror;
    modport bridge (input flushReqN, output flushAckN, output intcChipSelN,
                    output timerIrqMirror);
    modport intc   (output flushReqN, input flushAckN, input intcChipSelN,
                    input timerIrqMirror);
endinterface : asip_sideband_if

//--- rtl/asip_kbd_edge.sv
`timescale 1ns/10ps
module asip_kbd_edge
    import asip_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      kbdIrqIn,
    input  wire logic                      intAckPulse,
    output logic                           kbdPending,
    output logic [ASIP_IRQ_VEC_W-1:0]      ackVector
);
    logic syncA_ff, syncB_ff, prev_ff, pend_ff;
    logic [ASIP_IRQ_VEC_W-1:0] vec_ff;
    logic nxt_pend;
    logic [ASIP_IRQ_VEC_W-1:0] nxt_vec;

    always_comb begin
        nxt_pend = pend_ff;
        nxt_vec  = vec_ff;
        if (intAckPulse) begin
            // line dropped before acknowledge: answer spurious
            if (pend_ff && syncB_ff)
                nxt_vec = ASIP_KBD_VEC;
            else if (pend_ff)
                nxt_vec = ASIP_SPURIOUS_VEC;
            else
                nxt_vec = ASIP_NONE_VEC;
            nxt_pend = 1'b0;
        end
        // edge only, no level mode exists; set beats clear
        if (syncB_ff && !prev_ff)
            nxt_pend = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            prev_ff  <= 1'b0;
            pend_ff  <= 1'b0;
            vec_ff   <= ASIP_NONE_VEC;
        end else begin
            syncA_ff <= kbdIrqIn;
            syncB_ff <= syncA_ff;
            prev_ff  <= syncB_ff;
            pend_ff  <= nxt_pend;
            vec_ff   <= nxt_vec;
        end
    end

    assign kbdPending = pend_ff;
    assign ackVector  = vec_ff;
endmodule : asip_kbd_edge

//--- rtl/asip_bridge_end.sv
// Notes on behaviour
// - acknowledge low once flush completes
// - acknowledge changes only on clock edges
// - request flushes fast DMA write buffers
// - controller requests before sending any message
// - controller waits for acknowledge before message
// - request synchronous, sampled without synchroniser
// - chip select on enabled in-window cycles
// - acknowledge, chip select high in reset
// - acknowledge pin general output when unused
// - chip select, mirror general outputs when unused
// - request pin general input, no flush
// - mirror follows timer interrupt level
// - mirror low during and after reset
// - keyboard line always edge triggered
// - keyboard rising edge latched pending
// - keyboard source holds until acknowledge
// - early drop answers with spurious line
`timescale 1ns/10ps
module asip_bridge_end
    import asip_pkg::*;
#(
    parameter int                DRAIN_W = ASIP_DRAIN_W,
    parameter logic [DRAIN_W-1:0] DRAIN_CYCLES = ASIP_DRAIN_CYCLES
)(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    asip_sideband_if.bridge            sb,
    input  wire logic                  intcEnable,
    input  wire logic                  csEnable,
    input  wire logic [ASIP_ADDR_W-1:0] winBase,
    input  wire logic [ASIP_ADDR_W-1:0] winMask,
    input  wire logic                  pciCycleValid,
    input  wire logic [ASIP_ADDR_W-1:0] pciCycleAddr,
    input  wire logic                  fastBufPending,
    output logic                       flushBufReq,
    input  wire logic                  timerIrq,
    input  wire logic                  gpOutA,
    input  wire logic                  gpOutB,
    input  wire logic                  gpOutC,
    output logic                       gpInA,
    input  wire logic                  kbdIrqIn,
    input  wire logic                  intAckPulse,
    output logic                       kbdPending,
    output logic [ASIP_IRQ_VEC_W-1:0]  ackVector
);
    asip_flush_state_type state_ff, nxt_state;
    logic [DRAIN_W-1:0] drain_ff, nxt_drain;
    logic ackN_ff, nxt_ackN;
    logic csN_ff, nxt_csN;
    logic mirror_ff, nxt_mirror;
    logic gpIn_ff, nxt_gpIn;

    function automatic logic in_window(input logic [ASIP_ADDR_W-1:0] a,
                                       input logic [ASIP_ADDR_W-1:0] b,
                                       input logic [ASIP_ADDR_W-1:0] m);
        in_window = ((a & m) == (b & m));
    endfunction : in_window

    always_comb begin
        nxt_state = state_ff;
        nxt_drain = drain_ff;
        flushBufReq = 1'b0;
        case (state_ff)
            ASIP_FL_IDLE: begin
                // request is synchronous to our clock, read directly
                if (intcEnable && !sb.flushReqN) begin
                    nxt_state = ASIP_FL_DRAIN;
                    nxt_drain = DRAIN_CYCLES;
                end
            end
            ASIP_FL_DRAIN: begin
                flushBufReq = 1'b1;
                if (drain_ff != ASIP_DRAIN_ZERO[DRAIN_W-1:0])
                    nxt_drain = drain_ff - ASIP_DRAIN_ONE[DRAIN_W-1:0];
                else if (!fastBufPending)
                    nxt_state = ASIP_FL_ACK;
                if (!intcEnable)
                    nxt_state = ASIP_FL_IDLE;
            end
            ASIP_FL_ACK: begin
                // hold acknowledge until the controller drops request
                if (sb.flushReqN || !intcEnable)
                    nxt_state = ASIP_FL_IDLE;
            end
            default: nxt_state = ASIP_FL_IDLE;
        endcase
        if (intcEnable)
            nxt_ackN = (nxt_state != ASIP_FL_ACK) ? 1'b1 : 1'b0;
        else
            nxt_ackN = gpOutA;
        if (intcEnable)
            nxt_csN = !(csEnable && pciCycleValid
                        && in_window(pciCycleAddr, winBase, winMask));
        else
            nxt_csN = gpOutB;
        nxt_mirror = intcEnable ? timerIrq : gpOutC;
        nxt_gpIn   = intcEnable ? ASIP_PIN_IDLE : sb.flushReqN;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff  <= ASIP_FL_IDLE;
            drain_ff  <= ASIP_DRAIN_ZERO[DRAIN_W-1:0];
            ackN_ff   <= ASIP_PIN_IDLE;
            csN_ff    <= ASIP_PIN_IDLE;
            mirror_ff <= ASIP_MIRROR_RST;
            gpIn_ff   <= ASIP_PIN_IDLE;
        end else begin
            state_ff  <= nxt_state;
            drain_ff  <= nxt_drain;
            ackN_ff   <= nxt_ackN;
            csN_ff    <= nxt_csN;
            mirror_ff <= nxt_mirror;
            gpIn_ff   <= nxt_gpIn;
        end
    end

    assign sb.flushAckN      = ackN_ff;
    assign sb.intcChipSelN   = csN_ff;
    assign sb.timerIrqMirror = mirror_ff;
    assign gpInA             = gpIn_ff;

    asip_kbd_edge u_kbd (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .kbdIrqIn    (kbdIrqIn),
        .intAckPulse (intAckPulse),
        .kbdPending  (kbdPending),
        .ackVector   (ackVector)
    );
endmodule : asip_bridge_end

//--- rtl/asip_intc_end.sv
`timescale 1ns/10ps
module asip_intc_end
    import asip_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    asip_sideband_if.intc    sb,
    input  wire logic        msgPending,
    output logic             msgSend,
    output logic             timerSeen,
    output logic             chipSelSeen
);
    typedef enum logic [1:0] {
        ASIP_IC_IDLE,
        ASIP_IC_WAIT,
        ASIP_IC_SEND
    } asip_intc_state_type;
    asip_intc_state_type state_ff, nxt_state;
    logic reqN_ff, nxt_reqN;

    always_comb begin
        nxt_state = state_ff;
        nxt_reqN  = reqN_ff;
        msgSend   = 1'b0;
        case (state_ff)
            ASIP_IC_IDLE: begin
                if (msgPending) begin
                    nxt_state = ASIP_IC_WAIT;
                    nxt_reqN  = 1'b0;
                end
            end
            ASIP_IC_WAIT: begin
                if (!sb.flushAckN)
                    nxt_state = ASIP_IC_SEND;
            end
            ASIP_IC_SEND: begin
                msgSend   = 1'b1;
                nxt_reqN  = ASIP_PIN_IDLE;
                nxt_state = ASIP_IC_IDLE;
            end
            default: nxt_state = ASIP_IC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= ASIP_IC_IDLE;
            reqN_ff  <= ASIP_PIN_IDLE;
        end else begin
            state_ff <= nxt_state;
            reqN_ff  <= nxt_reqN;
        end
    end

    assign sb.flushReqN = reqN_ff;
    assign timerSeen    = sb.timerIrqMirror;
    assign chipSelSeen  = !sb.intcChipSelN;
endmodule : asip_intc_end

//--- tb/asip_sideband_monitor.sv
`timescale 1ns/10ps
module asip_sideband_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic intcEnable,
    input wire logic flushReqN,
    input wire logic flushAckN,
    input wire logic intcChipSelN,
    input wire logic timerIrqMirror,
    input wire logic flushBufReq,
    input wire logic fastBufPending
);
    property p_rst_pins;
        @(posedge core_clk) sys_rst |=> flushAckN && intcChipSelN;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("pins not idle after reset");
    property p_mirror_rst;
        @(posedge core_clk) sys_rst |=> !timerIrqMirror;
    endproperty
    a_mirror_rst: assert property (p_mirror_rst)
        else $error("mirror not low after reset");
    property p_ack_after_req;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        $fell(flushAckN) |-> $past(!flushReqN, 4);
    endproperty
    a_ack_after_req: assert property (p_ack_after_req)
        else $error("ack without drain time");
    property p_ack_bounded;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        $fell(flushReqN) |-> ##[1:60] !flushAckN;
    endproperty
    a_ack_bounded: assert property (p_ack_bounded)
        else $error("ack never came");
    property p_ack_holds;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        !flushAckN && !flushReqN |=> !flushAckN;
    endproperty
    a_ack_holds: assert property (p_ack_holds)
        else $error("ack dropped while requested");
    property p_ack_release;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        $rose(flushReqN) |-> ##[1:2] flushAckN;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("ack not released");
    property p_req_waits;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        $rose(flushReqN) |-> $past(!flushAckN);
    endproperty
    a_req_waits: assert property (p_req_waits)
        else $error("request released before ack");
    property p_req_holds;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        !flushReqN && flushAckN |=> !flushReqN;
    endproperty
    a_req_holds: assert property (p_req_holds)
        else $error("request withdrawn early");
    property p_ack_drained;
        @(posedge core_clk) disable iff (sys_rst || !intcEnable)
        $fell(flushAckN) |-> $past(flushBufReq && !fastBufPending);
    endproperty
    a_ack_drained: assert property (p_ack_drained)
        else $error("ack before buffers drained");
endmodule : asip_sideband_monitor

//--- tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a,b) begin testsRun++; if ((a) !== (b)) begin nFail++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_top;
    import asip_pkg::*;
    logic        core_clk, sys_rst, intcEn, csEn, cycV, fastP, tIrq;
    logic        gA, gB, gC, kbd, iAck, msgP, flushBufReq, gpInA;
    logic        kbdPending, msgSend, timerSeen, chipSelSeen;
    logic [31:0] cycA, winB, winM;
    logic [3:0]  ackVector;
    int          nFail, testsRun, nSent;
    asip_sideband_if sb ();
    asip_bridge_end asip_bridge_end_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .sb(sb), .intcEnable(intcEn), .csEnable(csEn),
        .winBase(winB), .winMask(winM),
        .pciCycleValid(cycV), .pciCycleAddr(cycA), .fastBufPending(fastP),
        .flushBufReq(flushBufReq), .timerIrq(tIrq), .gpOutA(gA),
        .gpOutB(gB), .gpOutC(gC), .gpInA(gpInA), .kbdIrqIn(kbd),
        .intAckPulse(iAck), .kbdPending(kbdPending), .ackVector(ackVector));
    asip_intc_end asip_intc_end_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .sb(sb), .msgPending(msgP), .msgSend(msgSend), .timerSeen(timerSeen),
        .chipSelSeen(chipSelSeen));
    asip_sideband_monitor asip_sideband_monitor_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .intcEnable(intcEn), .flushReqN(sb.flushReqN),
        .flushAckN(sb.flushAckN), .intcChipSelN(sb.intcChipSelN),
        .timerIrqMirror(sb.timerIrqMirror), .flushBufReq(flushBufReq),
        .fastBufPending(fastP));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (msgSend === 1'b1) nSent++;
    function automatic logic csExp(logic e, logic v, logic [31:0] a,
                                   logic [31:0] b, logic [31:0] m);
        return !(e && v && ((a & m) == (b & m)));
    endfunction : csExp
    task automatic closeOut();
        if (nFail == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : closeOut
    // mode only changes under reset, so the handshake checks never straddle it
    task automatic doReset(logic en);
        sys_rst <= 1'b1;
        intcEn  <= en;
        winB    <= $urandom;
        winM    <= ASIP_WIN_MASK_RST << ($urandom % 8);
        repeat (7) @(posedge core_clk);
        @(negedge core_clk);
        `CHK({sb.flushAckN, sb.intcChipSelN}, 2'b11)
        `CHK(sb.timerIrqMirror, 1'b0)
        `CHK(ackVector, ASIP_NONE_VEC)
        `CHK(kbdPending, 1'b0)
        @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask : doReset
    task automatic runRand(int n);
        logic exCs, exMir, exIn, exAck;
        bit   first;
        first = 1'b1;
        repeat (n) begin
            @(negedge core_clk);
            if (!first) begin
                `CHK(sb.intcChipSelN, exCs)
                `CHK(sb.timerIrqMirror, exMir)
                `CHK(chipSelSeen, !exCs)
                `CHK(timerSeen, exMir)
                `CHK(gpInA, exIn)
                if (!intcEn) begin
                    `CHK(sb.flushAckN, exAck)
                    `CHK(flushBufReq, 1'b0)
                end
            end
            exCs  = intcEn ? csExp(csEn, cycV, cycA, winB, winM) : gB;
            exMir = intcEn ? tIrq : gC;
            exIn  = intcEn ? 1'b1 : sb.flushReqN;
            exAck = gA;
            first = 1'b0;
            @(posedge core_clk);
            csEn  <= 1'($urandom);
            cycV  <= 1'($urandom);
            cycA  <= 1'($urandom) ? ((winB & winM) | ($urandom & ~winM))
                                  : $urandom;
            tIrq  <= 1'($urandom);
            gA    <= 1'($urandom);
            gB    <= 1'($urandom);
            gC    <= 1'($urandom);
            fastP <= ($urandom % 4) == 0;
            msgP  <= 1'($urandom);
        end
    endtask : runRand
    // with hold clear, drop the line early to force the spurious answer
    task automatic kbdCase(bit hold);
        @(posedge core_clk);
        kbd   <= 1'b1;
        // random stimulus rests here; empty buffers let the flush finish
        fastP <= 1'b0;
        repeat (5) @(posedge core_clk);
        if (!hold) kbd <= 1'b0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(kbdPending, 1'b1)
        @(posedge core_clk);
        iAck <= 1'b1;
        @(posedge core_clk);
        iAck <= 1'b0;
        kbd  <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(ackVector, hold ? ASIP_KBD_VEC : ASIP_SPURIOUS_VEC)
        `CHK(kbdPending, 1'b0)
        // an acknowledge with nothing latched answers with no request
        @(posedge core_clk);
        iAck <= 1'b1;
        @(posedge core_clk);
        iAck <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(ackVector, ASIP_NONE_VEC)
    endtask : kbdCase
    initial begin
        void'($urandom(32'h6D130D69));
        {sys_rst, intcEn, gA, gB} = 4'hF;
        {csEn, cycV, fastP, tIrq, gC, kbd, iAck, msgP} = 8'h00;
        {cycA, winB, winM} = {32'h0, ASIP_WIN_BASE_RST, ASIP_WIN_MASK_RST};
        nFail = 0;
        testsRun = 0;
        nSent = 0;
        doReset(1'b1);
        runRand(300);
        kbdCase(1'b1);
        kbdCase(1'b0);
        `CHK(nSent != 0, 1'b1)
        doReset(1'b0);
        runRand(60);
        doReset(1'b1);
        kbdCase(1'b1);
        closeOut();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        nFail++;
        closeOut();
    end
endmodule : tb_top
